// >>> tx_flow_defines.svh
// Purpose: Register offsets, field positions and reset values of the transmit endpoint flow.
// Assumes: A 32-bit Avalon-MM register port with byte addresses.
// Notes:   Definitions only.
`ifndef TX_FLOW_DEFINES_SVH
`define TX_FLOW_DEFINES_SVH

// ====================================
// Register offsets
`define TXF_OFS_CTRL     4'h0
`define TXF_OFS_STATUS   4'h4
`define TXF_OFS_COUNT    4'h8

// ====================================
// Control register fields
`define TXF_CTRL_EP_EN   0
`define TXF_CTRL_AUTO    1
`define TXF_CTRL_OE      2
`define TXF_CTRL_STALL   3
`define TXF_CTRL_IS_CTL  4
`define TXF_CTRL_W       5
`define TXF_CTRL_RESET   5'h00

// ====================================
// Status register fields
`define TXF_ST_ACK       0
`define TXF_ST_ERR       1
`define TXF_ST_VOID      2
`define TXF_ST_OVF       3
`define TXF_ST_URF       4
`define TXF_ST_DONE      5
`define TXF_ST_FILL_LO   6
`define TXF_ST_FILL_HI   7

// ====================================
// Fill state codes and count width
`define TXF_FILL_EMPTY   2'h0
`define TXF_FILL_BOTH    2'h3
`define TXF_COUNT_W      8

`endif

// >>> tx_flow_pkg.sv
// Purpose: Types shared by the transmit endpoint flow.
// Assumes: Nothing beyond the defines header.
// Notes:   States are one-hot.
package tx_flow_pkg;

	// ====================================
	// Transaction state of the endpoint.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_SEND = 2'h2
	} tx_state_t;

endpackage

// >>> tx_fill_tracker.sv
// Purpose: Tracks which buffer halves hold committed packets.
// Assumes: Commit and acknowledge are one-cycle pulses, never both while full or empty.
// Notes:   Bit 0 is half zero, bit 1 is half one.
`timescale 1ns/1ns
`include "tx_flow_defines.svh"

module tx_fill_tracker (
	input  wire logic       clk,         // System clock.
	input  wire logic       nrst,        // Asynchronous reset, active low.
	input  wire logic       commit,      // Packet committed by the byte count write.
	input  wire logic       release_pkt, // Host acknowledged the packet at the read half.
	output logic      [1:0] fill_state   // Halves holding packets.
);

	logic       load_half;
	logic       read_half;
	logic [1:0] next_fill_state;
	logic       next_load_half;
	logic       next_read_half;

	// ====================================
	// A commit marks the load half full, an acknowledge empties the read half.
	always_comb begin
		next_fill_state = fill_state;
		next_load_half  = load_half;
		next_read_half  = read_half;
		if (commit) begin
			next_fill_state[load_half] = 1'b1;
			next_load_half             = ~load_half;
		end
		if (release_pkt) begin
			next_fill_state[read_half] = 1'b0;
			next_read_half             = ~read_half;
		end
	end

	// Registers the fill state and both markers.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fill_state <= `TXF_FILL_EMPTY;
			load_half  <= 1'b0;
			read_half  <= 1'b0;
		end else begin
			fill_state <= next_fill_state;
			load_half  <= next_load_half;
			read_half  <= next_read_half;
		end
	end

endmodule // tx_fill_tracker

// >>> tx_bus_handshake.sv
// Purpose: Paces Avalon-MM accesses so each is answered one cycle after it is seen.
// Assumes: The master holds its request until it samples waitrequest low.
// Notes:   Waitrequest idles high and drops for exactly one cycle per access.
`timescale 1ns/1ns

module tx_bus_handshake (
	input  wire logic clk,         // System clock.
	input  wire logic nrst,        // Asynchronous reset, active low.
	input  wire logic request,     // Read or write is pending.
	output logic      waitrequest  // Low in the single cycle that completes the access.
);

	logic next_waitrequest;

	// ====================================
	// Drop for one cycle after a request meets a high waitrequest, then rise again.
	always_comb begin
		next_waitrequest = 1'b1;
		if (request && waitrequest) begin
			next_waitrequest = 1'b0;
		end
	end

	// Registers the waitrequest level.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= next_waitrequest;
		end
	end

endmodule // tx_bus_handshake

// >>> usb_nonisoch_tx_endpoint_flow.sv
// Purpose: Transmit endpoint flow for interrupt and bulk IN transfers.
// Assumes: USB side inputs other than the setup received level are one-cycle pulses from the serial interface engine.
// Notes:   Registers are reached over Avalon-MM; packet storage lives outside.
`timescale 1ns/1ns
`include "tx_flow_defines.svh"

// Behaviour
// - Error-free byte count write adds a packet to fill state; flags stay.
// - IN token when empty or output disabled gets NAK and void; with both halves full it also clears error and ack.
// - Control endpoint with setup received NAKs IN tokens even when stalled.
// - Acknowledged data advances read marker, lowers fill, sets ack, interrupts.
// - Handshake timeout reverses read pointer, keeps fill, sets error, interrupts.
// - Queued data with setup or disabled output: NAK, void, no interrupt.
// - Underrun on single packet: bit-stuff error, reverse, error and underrun set.
// - Underrun with both halves full behaves the same and keeps fill full.
// - IN token with pending underrun and error: NAK, void, nothing else changes.
// - Error from timeout alone lets data resend; ack then clears error.
// - Overrun loading an empty buffer sets overrun, keeps empty, NAKs later.
// - Overrun loading a second packet sets overrun, not error, NAKs later.
// - Overrun and underrun flags stay until firmware clears them.
// - Flow runs only with endpoint enable and automatic management on.
// - Serves non-isochronous interrupt and bulk transfers.
// - Error and ack update together, never both; either sets transmit done.
module usb_nonisoch_tx_endpoint_flow (
	input  wire logic        clk,                  // System clock, 25 MHz.
	input  wire logic        nrst,                 // Asynchronous reset, active low.
	input  wire logic [3:0]  avs_address,          // Register byte address.
	input  wire logic        avs_read,             // Register read request.
	input  wire logic        avs_write,            // Register write request.
	input  wire logic [31:0] avs_writedata,        // Register write data.
	output logic      [31:0] avs_readdata,         // Register read data.
	output logic             avs_waitrequest,      // Holds the master until the answer.
	input  wire logic        in_token,             // IN token for this endpoint.
	input  wire logic        host_ack,             // Host handshake after our data.
	input  wire logic        engine_timeout,       // No handshake before the engine timed out.
	input  wire logic        fifo_underrun,        // Buffer ran dry while sending.
	input  wire logic        fifo_overrun,         // Buffer overran while being loaded.
	input  wire logic        setup_received_flag,  // Setup packet received, level.
	output logic             resp_send,            // Pulse: send the queued data.
	output logic             resp_nak,             // Pulse: answer NAK.
	output logic             resp_stall,           // Pulse: answer STALL.
	output logic             resp_stuff_error,     // Pulse: end packet with bit-stuff error.
	output logic             read_advance,         // Pulse: advance the read marker.
	output logic             read_reverse,         // Pulse: reverse the read pointer.
	output logic             tx_interrupt,         // Pulse: transmit interrupt.
	output logic      [1:0]  tx_fill_state         // Halves holding packets.
);

	// ====================================
	// Declarations.
	tx_flow_pkg::tx_state_t          state;
	tx_flow_pkg::tx_state_t          next_state;
	logic [`TXF_CTRL_W-1:0]          ctrl;
	logic [`TXF_CTRL_W-1:0]          next_ctrl;
	logic [`TXF_COUNT_W-1:0]         byte_count;
	logic [`TXF_COUNT_W-1:0]         next_byte_count;
	logic                            tx_acknowledged_flag;
	logic                            tx_error_flag;
	logic                            tx_void_flag;
	logic                            tx_overrun_flag;
	logic                            tx_underrun_flag;
	logic                            tx_done_flag;
	logic                            next_ack;
	logic                            next_err;
	logic                            next_void;
	logic                            next_ovf;
	logic                            next_urf;
	logic                            next_done;
	logic                            next_resp_send;
	logic                            next_resp_nak;
	logic                            next_resp_stall;
	logic                            next_resp_stuff_error;
	logic                            next_read_advance;
	logic                            next_read_reverse;
	logic                            next_tx_interrupt;
	logic [31:0]                     next_readdata;
	logic                            bus_wr;
	logic                            bus_rd;
	logic                            count_wr;
	logic                            commit;
	logic                            flow_on;
	logic                            setup_block;
	logic                            tx_endpoint_enable;
	logic                            auto_transmit_management;
	logic                            tx_output_enable;
	logic                            tx_stall_bit;

	// Keeps a sticky flag: the set wins over a clear in the same cycle.
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// Tells whether a completing access hits a register offset.
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction

	// ====================================
	// Bus pacing and access qualifiers.
	tx_bus_handshake u_handshake (
		.clk         (clk),
		.nrst        (nrst),
		.request     (avs_read | avs_write),
		.waitrequest (avs_waitrequest)
	);

	// A write takes effect at the edge where waitrequest is seen low; a read is captured at the edge where it is seen high.
	assign bus_wr   = avs_write & ~avs_waitrequest;
	assign bus_rd   = avs_read & avs_waitrequest;
	assign count_wr = bus_wr & hit(avs_address, `TXF_OFS_COUNT);

	// Control bits as named levels.
	assign tx_endpoint_enable       = ctrl[`TXF_CTRL_EP_EN];
	assign auto_transmit_management = ctrl[`TXF_CTRL_AUTO];
	assign tx_output_enable         = ctrl[`TXF_CTRL_OE];
	assign tx_stall_bit             = ctrl[`TXF_CTRL_STALL];
	assign flow_on     = tx_endpoint_enable & auto_transmit_management;
	assign setup_block = ctrl[`TXF_CTRL_IS_CTL] & setup_received_flag;

	// A count write commits only when no overrun is pending or arriving, and a half is free.
	assign commit = count_wr & flow_on & ~tx_overrun_flag & ~fifo_overrun
		& (tx_fill_state != `TXF_FILL_BOTH);

	// ====================================
	// Fill state of the two buffer halves.
	tx_fill_tracker u_fill (
		.clk         (clk),
		.nrst        (nrst),
		.commit      (commit),
		.release_pkt (next_read_advance),
		.fill_state  (tx_fill_state)
	);

	// ====================================
	// Register file: control, byte count and read data.
	always_comb begin
		next_ctrl       = ctrl;
		next_byte_count = byte_count;
		next_readdata   = avs_readdata;
		if (bus_wr && hit(avs_address, `TXF_OFS_CTRL)) begin
			next_ctrl = avs_writedata[`TXF_CTRL_W-1:0];
		end else if (count_wr) begin
			next_byte_count = avs_writedata[`TXF_COUNT_W-1:0];
		end
		if (bus_rd) begin
			next_readdata = 32'h0000_0000;
			if (hit(avs_address, `TXF_OFS_CTRL)) begin
				next_readdata[`TXF_CTRL_W-1:0] = ctrl;
			end else if (hit(avs_address, `TXF_OFS_STATUS)) begin
				next_readdata[`TXF_ST_ACK]  = tx_acknowledged_flag;
				next_readdata[`TXF_ST_ERR]  = tx_error_flag;
				next_readdata[`TXF_ST_VOID] = tx_void_flag;
				next_readdata[`TXF_ST_OVF]  = tx_overrun_flag;
				next_readdata[`TXF_ST_URF]  = tx_underrun_flag;
				next_readdata[`TXF_ST_DONE] = tx_done_flag;
				next_readdata[`TXF_ST_FILL_HI:`TXF_ST_FILL_LO] = tx_fill_state;
			end else if (hit(avs_address, `TXF_OFS_COUNT)) begin
				next_readdata[`TXF_COUNT_W-1:0] = byte_count;
			end
		end
	end

	// Registers the register file.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl         <= `TXF_CTRL_RESET;
			byte_count   <= '0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ctrl         <= next_ctrl;
			byte_count   <= next_byte_count;
			avs_readdata <= next_readdata;
		end
	end

	// ====================================
	// Transaction flow: token decisions, outcomes and status flags.
	always_comb begin
		logic clr_ovf;
		logic clr_urf;
		logic clr_done;
		clr_ovf  = bus_wr & hit(avs_address, `TXF_OFS_STATUS) & avs_writedata[`TXF_ST_OVF];
		clr_urf  = bus_wr & hit(avs_address, `TXF_OFS_STATUS) & avs_writedata[`TXF_ST_URF];
		clr_done = bus_wr & hit(avs_address, `TXF_OFS_STATUS) & avs_writedata[`TXF_ST_DONE];
		next_state            = state;
		next_ack              = tx_acknowledged_flag;
		next_err              = tx_error_flag;
		next_void             = tx_void_flag;
		next_done             = tx_done_flag;
		next_resp_send        = 1'b0;
		next_resp_nak         = 1'b0;
		next_resp_stall       = 1'b0;
		next_resp_stuff_error = 1'b0;
		next_read_advance     = 1'b0;
		next_read_reverse     = 1'b0;
		next_tx_interrupt     = 1'b0;
		// Overruns come from loading or a count write while both halves are full.
		next_ovf = sticky(tx_overrun_flag, fifo_overrun
			| (count_wr & (tx_fill_state == `TXF_FILL_BOTH)), clr_ovf);
		next_urf = sticky(tx_underrun_flag, 1'b0, clr_urf);
		case (state)
			tx_flow_pkg::ST_IDLE: begin
				if (in_token && flow_on) begin
					if (setup_block || !tx_output_enable
						|| tx_fill_state == `TXF_FILL_EMPTY) begin
						next_resp_nak = 1'b1;
						next_void     = 1'b1;
						if (tx_fill_state == `TXF_FILL_BOTH) begin
							next_err = 1'b0;
							next_ack = 1'b0;
						end
					end else if (tx_underrun_flag || tx_overrun_flag) begin
						next_resp_nak = 1'b1;
						next_void     = 1'b1;
					end else if (tx_stall_bit) begin
						next_resp_stall = 1'b1;
					end else begin
						next_resp_send = 1'b1;
						next_state     = tx_flow_pkg::ST_SEND;
					end
				end
			end
			tx_flow_pkg::ST_SEND: begin
				if (fifo_underrun) begin
					next_resp_stuff_error = 1'b1;
					next_read_reverse     = 1'b1;
					next_urf              = 1'b1;
					next_err              = 1'b1;
					next_ack              = 1'b0;
					next_void             = 1'b0;
					next_done             = 1'b1;
					next_tx_interrupt     = 1'b1;
					next_state            = tx_flow_pkg::ST_IDLE;
				end else if (host_ack) begin
					next_read_advance = 1'b1;
					next_ack          = 1'b1;
					next_err          = 1'b0;
					next_void         = 1'b0;
					next_done         = 1'b1;
					next_tx_interrupt = 1'b1;
					next_state        = tx_flow_pkg::ST_IDLE;
				end else if (engine_timeout) begin
					next_read_reverse = 1'b1;
					next_err          = 1'b1;
					next_ack          = 1'b0;
					next_void         = 1'b0;
					next_done         = 1'b1;
					next_tx_interrupt = 1'b1;
					next_state        = tx_flow_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = tx_flow_pkg::ST_IDLE;
			end
		endcase
		// Transmit done is set by a completion and cleared by firmware; set wins.
		next_done = sticky(tx_done_flag, next_done & ~tx_done_flag, clr_done) | next_done;
		if (clr_done && !next_tx_interrupt) begin
			next_done = 1'b0;
		end
	end

	// Registers the flow state, flags and response pulses.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state                <= tx_flow_pkg::ST_IDLE;
			tx_acknowledged_flag <= 1'b0;
			tx_error_flag        <= 1'b0;
			tx_void_flag         <= 1'b0;
			tx_overrun_flag      <= 1'b0;
			tx_underrun_flag     <= 1'b0;
			tx_done_flag         <= 1'b0;
			resp_send            <= 1'b0;
			resp_nak             <= 1'b0;
			resp_stall           <= 1'b0;
			resp_stuff_error     <= 1'b0;
			read_advance         <= 1'b0;
			read_reverse         <= 1'b0;
			tx_interrupt         <= 1'b0;
		end else begin
			state                <= next_state;
			tx_acknowledged_flag <= next_ack;
			tx_error_flag        <= next_err;
			tx_void_flag         <= next_void;
			tx_overrun_flag      <= next_ovf;
			tx_underrun_flag     <= next_urf;
			tx_done_flag         <= next_done;
			resp_send            <= next_resp_send;
			resp_nak             <= next_resp_nak;
			resp_stall           <= next_resp_stall;
			resp_stuff_error     <= next_resp_stuff_error;
			read_advance         <= next_read_advance;
			read_reverse         <= next_read_reverse;
			tx_interrupt         <= next_tx_interrupt;
		end
	end

	// ====================================
	// Checks on the flow.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_empty_token_nak: assert property (state == tx_flow_pkg::ST_IDLE && in_token && flow_on
		&& tx_fill_state == `TXF_FILL_EMPTY |=> resp_nak && !resp_send && tx_void_flag
		&& !tx_interrupt) else $error("Empty IN token not NAKed as void.");
	a_setup_over_stall: assert property (state == tx_flow_pkg::ST_IDLE && in_token && flow_on
		&& setup_block |=> resp_nak && !resp_stall)
		else $error("Setup received did not force NAK.");
	a_ack_completes: assert property (state == tx_flow_pkg::ST_SEND && host_ack
		&& !fifo_underrun |=> read_advance && tx_acknowledged_flag && !tx_error_flag
		&& tx_interrupt ##1 tx_fill_state != $past(tx_fill_state, 2))
		else $error("Acknowledge did not complete the packet.");
	a_timeout_retry: assert property (state == tx_flow_pkg::ST_SEND && engine_timeout && !host_ack
		&& !fifo_underrun |=> read_reverse && tx_error_flag && !tx_acknowledged_flag
		&& tx_fill_state == $past(tx_fill_state))
		else $error("Timeout handled wrongly.");
	a_underrun_stuff: assert property (state == tx_flow_pkg::ST_SEND && fifo_underrun
		|=> resp_stuff_error && read_reverse && tx_underrun_flag && tx_error_flag
		&& tx_fill_state == $past(tx_fill_state))
		else $error("Underrun did not end with a stuff error.");
	a_flags_exclusive: assert property (!(tx_error_flag && tx_acknowledged_flag))
		else $error("Error and acknowledge both set.");
	a_done_follows: assert property ($rose(tx_error_flag) || $rose(tx_acknowledged_flag)
		|-> tx_done_flag) else $error("Transmit done missing.");
	a_overrun_sticky: assert property (tx_overrun_flag && !(bus_wr
		&& hit(avs_address, `TXF_OFS_STATUS)) |=> tx_overrun_flag)
		else $error("Overrun flag dropped by hardware.");
	a_commit_flags: assert property (commit |=> tx_fill_state != `TXF_FILL_EMPTY
		&& $stable(tx_error_flag) && $stable(tx_acknowledged_flag))
		else $error("Commit did not add a packet cleanly.");
	a_overrun_blocks: assert property (state == tx_flow_pkg::ST_IDLE && in_token && flow_on
		&& tx_overrun_flag |=> !resp_send) else $error("Sent data with overrun.");

endmodule // usb_nonisoch_tx_endpoint_flow

// >>> usb_host_model.sv
// Purpose: Stand-in for the host and serial engine that issue IN tokens and outcomes.
// Assumes: Response pulses stand in the cycle after the token edge.
// Notes:   An outcome is sent only after a data response, gap cycles later.
`timescale 1ns/1ns

module usb_host_model (
	input  wire logic clk,              // System clock.
	input  wire logic resp_send,        // Data response.
	input  wire logic resp_nak,         // NAK response.
	input  wire logic resp_stall,       // STALL response.
	input  wire logic resp_stuff_error, // Bit-stuff error ending.
	input  wire logic read_advance,     // Read marker advanced.
	input  wire logic read_reverse,     // Read pointer reversed.
	input  wire logic tx_interrupt,     // Transmit interrupt.
	output logic      in_token,         // IN token pulse.
	output logic      host_ack,         // Handshake pulse.
	output logic      engine_timeout,   // Timeout pulse.
	output logic      fifo_underrun     // Underrun pulse.
);
	logic [1:0] seen_resp; // 1 data, 2 NAK, 3 STALL.
	logic [3:0] seen_evt;  // Stuff error, interrupt, advance, reverse.

	// All pulse lines rest low between transactions.
	initial begin
		in_token = 1'b0;
		host_ack = 1'b0;
		engine_timeout = 1'b0;
		fifo_underrun = 1'b0;
	end

	// One transaction: mode 0 acknowledge, 1 timeout, 2 underrun, 3 silent.
	task automatic transact(input logic [1:0] mode, input int gap);
		int i;
		seen_resp = 2'h0;
		seen_evt = 4'h0;
		@(posedge clk);
		in_token <= 1'b1;
		@(posedge clk);
		in_token <= 1'b0;
		for (i = 0; i < gap + 5; i++) begin
			@(posedge clk);
			if (i == 0)
				seen_resp = {resp_nak | resp_stall, resp_send | resp_stall};
			if (i == gap && seen_resp == 2'h1) begin
				host_ack <= (mode == 2'h0);
				engine_timeout <= (mode == 2'h1);
				fifo_underrun <= (mode == 2'h2);
			end
			if (i == gap + 1) begin
				host_ack <= 1'b0;
				engine_timeout <= 1'b0;
				fifo_underrun <= 1'b0;
			end
			seen_evt = seen_evt | {resp_stuff_error, tx_interrupt, read_advance, read_reverse};
		end
	endtask
endmodule // usb_host_model

// >>> usb_nonisoch_tx_endpoint_flow_bench.sv
// Purpose: Self-checking bench for the transmit endpoint flow.
// Assumes: Status reads back ack, err, void, ovf, urf, done and fill in bits 7:0.
// Notes:   Half order follows commits: half zero first, then alternating.
`timescale 1ns/1ns

module usb_nonisoch_tx_endpoint_flow_bench;
	logic        clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        in_token, host_ack, engine_timeout, fifo_underrun, fifo_overrun;
	logic        setup_received_flag, resp_send, resp_nak, resp_stall, resp_stuff_error;
	logic        read_advance, read_reverse, tx_interrupt;
	logic [1:0]  tx_fill_state;
	int          num_errors, compares;

	usb_nonisoch_tx_endpoint_flow dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .in_token, .host_ack, .engine_timeout,
		.fifo_underrun, .fifo_overrun, .setup_received_flag, .resp_send, .resp_nak,
		.resp_stall, .resp_stuff_error, .read_advance, .read_reverse, .tx_interrupt,
		.tx_fill_state);
	usb_host_model host (.clk, .resp_send, .resp_nak, .resp_stall, .resp_stuff_error,
		.read_advance, .read_reverse, .tx_interrupt, .in_token, .host_ack, .engine_timeout,
		.fifo_underrun);

	// Clock of 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_sim;
		$display("Errors %0d of %0d compares", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Avalon-MM access held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i == 20) begin
			num_errors++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d});
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic st(input logic [7:0] e);
		bus(1'b0, 4'h4, 32'h00000000);
		chk(q, {24'h000000, e});
		chk({30'h0, tx_fill_state}, {30'h0, e[7:6]});
	endtask

	// Token with outcome; compares response code and the event pulses.
	task automatic tk(input logic [1:0] m, input int g, input logic [1:0] r, input logic [3:0] e);
		host.transact(m, g);
		chk({26'h0, host.seen_resp, host.seen_evt}, {26'h0, r, e});
	endtask

	task automatic ovf;
		@(posedge clk);
		fifo_overrun <= 1'b1;
		@(posedge clk);
		fifo_overrun <= 1'b0;
	endtask

	// Main sequence.
	initial begin
		nrst = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		fifo_overrun = 1'b0;
		setup_received_flag = 1'b0;
		num_errors = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, 4'hC, 32'h00000000);
		chk(q, 32'h00000000);
		st(8'h00);
		wr(4'h8, 8'h10);
		tk(2'h3, 0, 2'h0, 4'h0);
		st(8'h00);
		wr(4'h0, 8'h07);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'h04);
		wr(4'h8, 8'h10);
		st(8'h44);
		tk(2'h0, 2, 2'h1, 4'h6);
		st(8'h21);
		wr(4'h4, 8'h20);
		wr(4'h8, 8'h10);
		wr(4'h8, 8'h10);
		st(8'hC1);
		tk(2'h1, 0, 2'h1, 4'h5);
		st(8'hE2);
		tk(2'h0, 0, 2'h1, 4'h6);
		st(8'h61);
		wr(4'h0, 8'h03);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'h65);
		wr(4'h8, 8'h10);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'hE4);
		wr(4'h0, 8'h1F);
		setup_received_flag <= 1'b1;
		tk(2'h0, 0, 2'h2, 4'h0);
		setup_received_flag <= 1'b0;
		tk(2'h0, 0, 2'h3, 4'h0);
		wr(4'h0, 8'h07);
		wr(4'h4, 8'h20);
		tk(2'h2, 0, 2'h1, 4'hD);
		st(8'hF2);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'hF6);
		wr(4'h4, 8'h10);
		tk(2'h0, 0, 2'h1, 4'h6);
		st(8'hA1);
		ovf();
		st(8'hA9);
		wr(4'h8, 8'h10);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'hAD);
		wr(4'h4, 8'h08);
		st(8'hA5);
		tk(2'h2, 0, 2'h1, 4'hD);
		st(8'hB2);
		wr(4'h4, 8'h30);
		tk(2'h0, 0, 2'h1, 4'h6);
		st(8'h21);
		ovf();
		st(8'h29);
		tk(2'h0, 0, 2'h2, 4'h0);
		st(8'h2D);
		end_sim();
	end
endmodule // usb_nonisoch_tx_endpoint_flow_bench
